// >>> design/fidp_host.v
// Host controller: identification reads and sector protect/unprotect cycles
//
// What this block does
// - Identification read drives chip enable low, output enable low, write enable high, A6 low.
// - Protect steps run as ordinary bus cycles with reset at elevated voltage.
// - Unprotect first protects every sector address, then issues the unprotect write.
// - Unprotect clears all units; host then re-protects wanted units singly.
`timescale 1ns/100ps
`include "fidp_regs.vh"
module fidp_host #(
    parameter ACCESS_NS = `FIDP_ACCESS_NS,
    parameter PULSE_NS = `FIDP_PULSE_NS
) (
    input wire core_clk_i,
    input wire arst_n_i,
    input wire clk_en_i,
    input wire start_i,
    input wire [1:0] op_i,
    input wire [1:0] id_sel_i,
    input wire [7:0] sector_addr_i,
    input wire bottom_boot_i,
    input wire [15:0] flash_dq_i,
    output wire ready_o,
    output reg done_o,
    output reg [15:0] id_data_o,
    output reg [4:0] unit_o,
    output reg boot_outer_o,
    output reg [19:0] flash_addr_o,
    output reg [15:0] flash_dq_o,
    output reg flash_dq_oe_n_o,
    output reg flash_ce_n_o,
    output reg flash_oe_n_o,
    output reg flash_we_n_o,
    output reg flash_byte_n_o,
    output reg a9_high_volt_o,
    output reg reset_high_volt_o
);
    ////////////////////////////////////////////////////////////////////////
    // Timing counts derived from the clock period
    // Whole-cycle counts, rounded up so no bus phase ends early
    localparam integer ACCESS_CYC_I = ((ACCESS_NS + `FIDP_CLK_NS - 1) / `FIDP_CLK_NS);
    localparam integer PULSE_CYC_I = ((PULSE_NS + `FIDP_CLK_NS - 1) / `FIDP_CLK_NS);
    localparam integer SETUP_CYC_I = ((`FIDP_SETUP_NS + `FIDP_CLK_NS - 1) / `FIDP_CLK_NS);
    // Cut to the counter width on purpose
    localparam [7:0] ACCESS_CYC = ACCESS_CYC_I[7:0];
    localparam [7:0] PULSE_CYC = PULSE_CYC_I[7:0];
    localparam [7:0] SETUP_CYC = SETUP_CYC_I[7:0];
    // One-hot states
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_SETUP = 5'h02;
    localparam [4:0] ST_READ = 5'h04;
    localparam [4:0] ST_WRITE = 5'h08;
    localparam [4:0] ST_DONE = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers for flash data pins
    reg [15:0] dq_meta;
    reg [15:0] dq_sync;
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dq_meta <= 16'h0000;
            dq_sync <= 16'h0000;
        end else if (clk_en_i) begin
            dq_meta <= flash_dq_i;
            dq_sync <= dq_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sector map lookup for status reporting
    wire [4:0] map_unit;
    wire map_outer;
    fidp_sector_map u_map (
        .sector_addr_i(sector_addr_i),
        .bottom_boot_i(bottom_boot_i),
        .unit_o(map_unit),
        .boot_outer_o(map_outer)
    );

    // Build address for an identification or protect cycle
    function [19:0] fidp_addr;
        input [7:0] sec;
        input [1:0] sel;
        input a1;
        begin
            fidp_addr = 20'h00000;
            fidp_addr[`FIDP_SEC_LSB+`FIDP_SEC_W-1:`FIDP_SEC_LSB] = sec;
            fidp_addr[`FIDP_A6_BIT] = 1'b0;
            fidp_addr[`FIDP_A1_BIT] = a1 | sel[1];
            fidp_addr[`FIDP_A0_BIT] = sel[0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    reg [4:0] state;
    reg [7:0] cnt;
    reg [1:0] op;

    ////////////////////////////////////////////////////////////////////////
    // Protect sweep ahead of an unprotect
    // Every sector address is protected first, so the unprotect write
    // never meets an unprotected sector; costs 256 extra write cycles.
    reg sweeping;
    reg [7:0] sweep_sec;

    // Ready only in idle; a start seen elsewhere is dropped, not queued
    assign ready_o = (state == ST_IDLE);
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ST_IDLE;
            cnt <= 8'h00;
            op <= `FIDP_OP_READ_ID;
            sweeping <= 1'b0;
            sweep_sec <= 8'h00;
            done_o <= 1'b0;
            id_data_o <= 16'h0000;
            unit_o <= 5'h00;
            boot_outer_o <= 1'b0;
            flash_addr_o <= 20'h00000;
            flash_dq_o <= 16'h0000;
            flash_dq_oe_n_o <= 1'b1;
            flash_ce_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            flash_we_n_o <= 1'b1;
            flash_byte_n_o <= 1'b1;
            a9_high_volt_o <= 1'b0;
            reset_high_volt_o <= 1'b0;
        end else if (clk_en_i) begin
            done_o <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start_i) begin
                        op <= op_i;
                        unit_o <= map_unit;
                        boot_outer_o <= map_outer;
                        flash_byte_n_o <= 1'b1;
                        // Unprotect starts its protect sweep at the lowest sector
                        sweeping <= (op_i == `FIDP_OP_UNPROTECT);
                        sweep_sec <= 8'h00;
                        flash_addr_o <= fidp_addr((op_i == `FIDP_OP_UNPROTECT) ? 8'h00 : sector_addr_i, id_sel_i,
                            op_i != `FIDP_OP_READ_ID);
                        a9_high_volt_o <= (op_i == `FIDP_OP_READ_ID);
                        reset_high_volt_o <= (op_i != `FIDP_OP_READ_ID);
                        flash_ce_n_o <= 1'b0;
                        cnt <= SETUP_CYC;
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cnt <= 8'h01) begin
                        if (op == `FIDP_OP_READ_ID) begin
                            flash_oe_n_o <= 1'b0;
                            flash_we_n_o <= 1'b1;
                            cnt <= ACCESS_CYC;
                            state <= ST_READ;
                        end else begin
                            // Unprotect flagged on A6 after the sweep, protect keeps A6 low
                            flash_addr_o[`FIDP_A6_BIT] <= (op == `FIDP_OP_UNPROTECT) && !sweeping;
                            flash_we_n_o <= 1'b0;
                            flash_dq_oe_n_o <= 1'b0;
                            flash_dq_o <= 16'h0000;
                            cnt <= PULSE_CYC;
                            state <= ST_WRITE;
                        end
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                ST_READ: begin
                    if (cnt <= 8'h01) begin
                        id_data_o <= dq_sync;
                        flash_oe_n_o <= 1'b1;
                        state <= ST_DONE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                ST_WRITE: begin
                    if (cnt <= 8'h01) begin
                        flash_we_n_o <= 1'b1;
                        flash_dq_oe_n_o <= 1'b1;
                        state <= ST_DONE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                ST_DONE: begin
                    if (sweeping) begin
                        // Chip stays selected; next protect write, or the unprotect after the last sector
                        sweeping <= (sweep_sec != `FIDP_SEC_LAST);
                        sweep_sec <= sweep_sec + 8'h01;
                        flash_addr_o <= fidp_addr(sweep_sec + 8'h01, 2'h0, 1'b1);
                        cnt <= SETUP_CYC;
                        state <= ST_SETUP;
                    end else begin
                        // Release the chip and report the end of the operation
                        flash_ce_n_o <= 1'b1;
                        a9_high_volt_o <= 1'b0;
                        reset_high_volt_o <= 1'b0;
                        done_o <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> design/fidp_regs.vh
// Constants for the flash identification and sector-protection host controller
`ifndef FIDP_REGS_VH
`define FIDP_REGS_VH
// Address bit positions on the flash address bus (word mode, A19..A0)
`define FIDP_ADDR_W 20
`define FIDP_A9_BIT 9
`define FIDP_A6_BIT 6
`define FIDP_A1_BIT 1
`define FIDP_A0_BIT 0
`define FIDP_SEC_LSB 12
`define FIDP_SEC_W 8
`define FIDP_SEC_LAST 8'hFF
// Identification item select on A1:A0
`define FIDP_ID_MANUF 2'h0
`define FIDP_ID_DEVICE 2'h1
`define FIDP_ID_PROT 2'h2
`define FIDP_ID_CONT 2'h3
// Protection status values
`define FIDP_PROT_YES 8'h01
`define FIDP_PROT_NO 8'h00
// Host operations
`define FIDP_OP_READ_ID 2'h0
`define FIDP_OP_PROTECT 2'h1
`define FIDP_OP_UNPROTECT 2'h2
// Bus cycle timing in ns
`define FIDP_CLK_NS 10
`define FIDP_ACCESS_NS 300
`define FIDP_SETUP_NS 50
`define FIDP_PULSE_NS 100
`define FIDP_CNT_W 8
`endif

// >>> design/fidp_sector_map.v
// Sector address to protection unit index for top and bottom boot layouts
`timescale 1ns/100ps
module fidp_sector_map (
    input wire [7:0] sector_addr_i,
    input wire bottom_boot_i,
    output reg [4:0] unit_o,
    output reg boot_outer_o
);
    // Mirror bottom layout onto top layout then decode groups
    reg [7:0] top_addr;
    always @* begin
        top_addr = bottom_boot_i ? ~sector_addr_i : sector_addr_i;
        boot_outer_o = (top_addr[7:1] == 7'h7F);
        if (top_addr[7:3] == 5'h1F) begin
            unit_o = {2'h0, top_addr[2:0]} + 5'h0A;
        end else if (top_addr[7:5] == 3'h7) begin
            unit_o = 5'h09;
        end else if (top_addr[7:3] == 5'h00) begin
            unit_o = 5'h00;
        end else if (top_addr[7:5] == 3'h0) begin
            unit_o = 5'h01;
        end else begin
            unit_o = {2'h0, top_addr[7:5]} + 5'h01;
        end
    end
endmodule

// >>> dv/fidp_flash_model.sv
// Flash device model: identification codes and per-sector protection
`timescale 1ns/100ps
module fidp_flash_model #(
    parameter [7:0] MANUF_ID = 8'hA5, // Arbitrary value
    parameter [7:0] DEV_ID = 8'h5A, // Arbitrary value
    parameter [7:0] EXTRA_ID = 8'h3C, // Arbitrary value
    parameter [7:0] CONT_ID = 8'hC3 // Arbitrary value
) (
    input wire [19:0] addr_i,
    input wire ce_n_i,
    input wire oe_n_i,
    input wire we_n_i,
    input wire a9_hv_i,
    input wire rst_hv_i,
    output reg [15:0] dq_o
);
    reg prot [0:255];
    reg [15:0] last = 16'h0000;
    integer i;
    integer j;
    reg order_err = 1'b0;
    // Every sector leaves the factory unprotected
    initial for (i = 0; i < 256; i = i + 1) prot[i] = 1'b0;
    // Identification read; released bus shows the inverse of the last word
    always @* begin
        if (!ce_n_i && !oe_n_i && a9_hv_i) begin
            case (addr_i[1:0])
                2'h0: dq_o = {8'h00, MANUF_ID};
                2'h1: dq_o = {EXTRA_ID, DEV_ID};
                2'h2: dq_o = {15'h0000, prot[addr_i[19:12]]};
                default: dq_o = {8'h00, CONT_ID};
            endcase
            last = dq_o;
        end else dq_o = ~last;
    end
    // Protect or unprotect-all on the rising write strobe
    always @(posedge we_n_i) begin
        if (!ce_n_i && oe_n_i && rst_hv_i) begin
            if (addr_i[6]) begin
                // Flag an unprotect that meets a sector still unprotected
                for (j = 0; j < 256; j = j + 1) begin
                    if (!prot[j]) begin
                        order_err = 1'b1;
                    end
                end
                for (i = 0; i < 256; i = i + 1) prot[i] = 1'b0;
            end else prot[addr_i[19:12]] = 1'b1;
        end
    end
endmodule

// >>> dv/fidp_host_properties.sv
// Checker: bus cycle shapes and lengths of the host controller
`timescale 1ns/100ps
`include "fidp_regs.vh"
module fidp_host_chk (
    input wire core_clk_i,
    input wire arst_n_i,
    input wire clk_en_i,
    input wire start_i,
    input wire [1:0] op_i,
    input wire [1:0] id_sel_i,
    input wire [7:0] sector_addr_i,
    input wire ready_o,
    input wire done_o,
    input wire [19:0] flash_addr_o,
    input wire flash_dq_oe_n_o,
    input wire flash_ce_n_o,
    input wire flash_oe_n_o,
    input wire flash_we_n_o,
    input wire flash_byte_n_o,
    input wire a9_high_volt_o,
    input wire reset_high_volt_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    wire take = clk_en_i && ready_o && start_i;
    sequence s_rd; take && op_i == `FIDP_OP_READ_ID; endsequence
    sequence s_wr; take && op_i == `FIDP_OP_PROTECT; endsequence
    sequence s_un; take && op_i == `FIDP_OP_UNPROTECT; endsequence
    reg [1:0] last_op = 2'h0;
    // Operation of the latest accepted request
    always @(posedge core_clk_i) begin
        if (take) begin
            last_op <= op_i;
        end
    end
    property p_rd_len; s_rd |-> ##37 done_o; endproperty
    a_rd_len: assert property (p_rd_len) else $error("read length wrong");
    property p_wr_len; s_wr |-> ##17 done_o; endproperty
    a_wr_len: assert property (p_wr_len) else $error("write length wrong");
    property p_rd_addr; s_rd |=> flash_addr_o[1:0] == $past(id_sel_i) && flash_addr_o[19:12] == $past(sector_addr_i)
        && a9_high_volt_o; endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("read address wrong");
    property p_rd_strb; !flash_oe_n_o |-> !flash_ce_n_o && flash_we_n_o && !flash_addr_o[6]; endproperty
    a_rd_strb: assert property (p_rd_strb) else $error("read strobes wrong");
    property p_wr_strb; !flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && reset_high_volt_o && !flash_dq_oe_n_o;
    endproperty
    a_wr_strb: assert property (p_wr_strb) else $error("write strobes wrong");
    property p_we_len; $fell(flash_we_n_o) |-> (!flash_we_n_o)[*5] ##6 $rose(flash_we_n_o); endproperty
    a_we_len: assert property (p_we_len) else $error("write pulse length wrong");
    property p_sweep; s_un |-> ##6 !flash_addr_o[6] && !flash_we_n_o; endproperty
    a_sweep: assert property (p_sweep) else $error("unprotect not preceded by protect");
    property p_unprot; done_o && last_op == `FIDP_OP_UNPROTECT |-> flash_addr_o[6] && flash_addr_o[1]; endproperty
    a_unprot: assert property (p_unprot) else $error("unprotect marker missing");
    property p_done; done_o |=> !done_o && ready_o; endproperty
    a_done: assert property (p_done) else $error("done not a single pulse");
    property p_byte; flash_byte_n_o; endproperty
    a_byte: assert property (p_byte) else $error("byte select low");
endmodule
bind fidp_host fidp_host_chk chk_u (.*);

// >>> dv/tb.sv
// Testbench: identification reads and sector protection through the host controller
`timescale 1ns/100ps
module tb;
    reg core_clk_i = 0, arst_n_i = 0, start_i = 0, bottom_boot_i = 0, clk_en = 1;
    reg [1:0] op_i = 0, id_sel_i = 0;
    reg [7:0] sector_addr_i = 0;
    wire [15:0] dq_o, dev_dq, id_data_o;
    wire [19:0] addr;
    wire [4:0] unit_o;
    wire ready_o, done_o, ce_n, oe_n, we_n, dq_oe_n, a9_hv, rst_hv, boot_outer_o;
    integer error_cnt = 0, cmp_count = 0, cyc = 0;
    always #5 core_clk_i = ~core_clk_i;
    fidp_host dut_u (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en), .start_i(start_i),
        .op_i(op_i), .id_sel_i(id_sel_i), .sector_addr_i(sector_addr_i), .bottom_boot_i(bottom_boot_i),
        .flash_dq_i(dq_oe_n ? dev_dq : dq_o), .ready_o(ready_o), .done_o(done_o), .id_data_o(id_data_o),
        .unit_o(unit_o), .boot_outer_o(boot_outer_o), .flash_addr_o(addr), .flash_dq_o(dq_o),
        .flash_dq_oe_n_o(dq_oe_n), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
        .flash_byte_n_o(), .a9_high_volt_o(a9_hv), .reset_high_volt_o(rst_hv));
    fidp_flash_model flash_u (.addr_i(addr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .a9_hv_i(a9_hv),
        .rst_hv_i(rst_hv), .dq_o(dev_dq));
    task check(input [15:0] seen, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task run(input [1:0] op, input [1:0] sel, input [7:0] sec);
        integer n;
        begin
            @(negedge core_clk_i);
            start_i = 1;
            op_i = op;
            id_sel_i = sel;
            sector_addr_i = sec;
            @(negedge core_clk_i);
            start_i = 0;
            n = 0;
            while (done_o !== 1'b1 && n < 5000) begin
                @(negedge core_clk_i);
                n = n + 1;
            end
            check(n < 5000, 1);
        end
    endtask
    task t_ids;
        begin
            run(0, 0, 8'h00);
            check(id_data_o[7:0], flash_u.MANUF_ID);
            run(0, 1, 8'h00);
            check(id_data_o, {flash_u.EXTRA_ID, flash_u.DEV_ID});
            run(0, 3, 8'h00);
            check(id_data_o[7:0], flash_u.CONT_ID);
            $display("identification test done");
        end
    endtask
    task t_freeze;
        begin
            @(negedge core_clk_i);
            clk_en = 0;
            start_i = 1;
            op_i = 1;
            repeat (3) @(negedge core_clk_i);
            check(ready_o, 1);
            check(ce_n, 1);
            check(done_o, 0);
            start_i = 0;
            clk_en = 1;
            $display("clock enable test done");
        end
    endtask
    task t_prot;
        begin
            run(0, 2, 8'hFF);
            check(id_data_o[7:0], 8'h00);
            check(boot_outer_o, 1);
            check(unit_o, 5'h11);
            run(1, 0, 8'hFF);
            run(0, 2, 8'hFF);
            check(id_data_o[7:0], 8'h01);
            run(0, 2, 8'h10);
            check(id_data_o[7:0], 8'h00);
            check(unit_o, 5'h01);
            run(1, 0, 8'h00);
            run(2, 0, 8'h00);
            check(flash_u.order_err, 0);
            run(0, 2, 8'hFF);
            check(id_data_o[7:0], 8'h00);
            bottom_boot_i = 1;
            run(0, 2, 8'h00);
            check(id_data_o[7:0], 8'h00);
            check(boot_outer_o, 1);
            check(unit_o, 5'h11);
            run(1, 0, 8'h00);
            run(0, 2, 8'h00);
            check(id_data_o[7:0], 8'h01);
            run(0, 2, 8'hFF);
            check(id_data_o[7:0], 8'h00);
            $display("protection test done");
        end
    endtask
    task results;
        begin
            $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
            if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    // Hang guard
    always @(posedge core_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            results;
        end
    end
    initial begin
        repeat (12) @(negedge core_clk_i);
        arst_n_i = 1;
        t_ids;
        t_freeze;
        t_prot;
        results;
    end
endmodule
